// File: rtl/cpctl_copper_ctrl.sv
/*
 * Copper port control register with soft reset, loopback, deferred speed,
 * duplex and auto-negotiation settings, power down and isolate, reached over
 * the serial management pins.
 * Assumes the second power-down bit, keep-alive bit, loopback speed and the
 * advertisement bits arrive from their own registers, synchronous to clk_sys.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - soft reset touches pages 0,2,3,5,7 only
// - reset bit starts at once, self-clears
// - loopback returns MAC data, drops line link
// - loopback speed comes from separate field
// - speed bits 6,13: 00/01/10 = 10/100/1000
// - speed, duplex, AN enable commit on trigger
// - AN enable resets to one
// - forced 1000 still negotiates, advertises duplex
// - forced 1000 ignores other advertisement bits
// - powered only when both power bits zero
// - power-up does soft reset and restart
// - RGMII stays up in power down if keep-alive
// - AN restarts after hardware and soft reset
// - restart bit self-clears, resets to zero
// - access through management read/write frames
// - self-clearing bits act at once, clear themselves
module cpctl_copper_ctrl
   import cpctl_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        mdc,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   input  wire logic [4:0]  phy_addr,
   input  wire logic        pd_ext,
   input  wire logic        rgmii_keepalive,
   input  wire logic [1:0]  lb_speed,
   input  wire logic [3:0]  adv_base,
   input  wire logic [1:0]  adv_1000,
   output logic [1:0]       link_speed,
   output logic             an_active,
   output logic [5:0]       adv_ability,
   output logic             loopback,
   output logic             link_enable,
   output logic             mac_port_en,
   output logic             power_down,
   output logic             rgmii_down,
   output logic [7:0]       srst_pages,
   output logic             an_restart
);

   cpctl_state_t state_ff;
   logic [7:0]   srst_cnt_ff;
   logic [7:0]   an_cnt_ff;
   logic [7:0]   page_ff;
   logic         loop_ff;
   logic         iso_ff;
   logic         pd_ff;
   logic         pd_act_prev_ff;
   logic         anr_busy_ff;
   logic [1:0]   spd_pend_ff;
   logic         an_pend_ff;
   logic         dup_pend_ff;
   logic [1:0]   spd_cur_ff;
   logic         an_cur_ff;
   logic         dup_cur_ff;
   logic [1:0]   link_speed_ff;
   logic         an_active_ff;
   logic [5:0]   adv_ff;
   logic         link_en_ff;
   logic         mac_en_ff;
   logic         power_down_ff;
   logic         rgmii_down_ff;
   logic [7:0]   srst_pages_ff;
   logic         an_restart_ff;

   logic [4:0]   acc_reg;
   logic         wr_stb;
   logic [15:0]  wr_data;
   wire  [15:0]  rd_data;
   wire  [15:0]  ctl_rd;
   wire          wr_ctl;
   wire          wr_page;
   wire          pd_act;
   wire          pd_exit;
   wire          in_srst;
   wire          srst_done;
   wire          srst_req;
   wire          anr_req;
   wire          commit;
   wire          forced_1g;
   wire  [1:0]   nxt_spd_pend;
   wire          nxt_an_pend;
   wire          nxt_dup_pend;

   cpctl_mdio_slave u_mdio (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .mdc      (mdc),
      .mdio_in  (mdio_in),
      .mdio_out (mdio_out),
      .mdio_oe  (mdio_oe),
      .phy_addr (phy_addr),
      .acc_reg  (acc_reg),
      .rd_data  (rd_data),
      .wr_stb   (wr_stb),
      .wr_data  (wr_data)
   );

   // ----------------------------------------------------------------
   // decode and readback
   // ----------------------------------------------------------------
   assign wr_ctl  = wr_stb & (acc_reg == REG_CTRL) & (page_ff == PAGE_COPPER);
   assign wr_page = wr_stb & (acc_reg == REG_PAGE);
   assign in_srst = (state_ff == ST_SRST);

   // readback shows the written value of deferred fields, not the active one
   assign ctl_rd = {in_srst, loop_ff, spd_pend_ff[0], an_pend_ff, pd_ff, iso_ff,
                    anr_busy_ff, dup_pend_ff, 1'b0, spd_pend_ff[1], 6'h00};
   assign rd_data = (acc_reg == REG_PAGE) ? {8'h00, page_ff} :
                    ((acc_reg == REG_CTRL) && (page_ff == PAGE_COPPER)) ? ctl_rd :
                    16'h0000;

   // ----------------------------------------------------------------
   // triggers
   // ----------------------------------------------------------------
   assign pd_act    = pd_ff | pd_ext;
   assign pd_exit   = pd_act_prev_ff & ~pd_act;
   assign srst_done = in_srst & (srst_cnt_ff == 8'h01);
   assign srst_req  = (wr_ctl & wr_data[CTL_RST]) | pd_exit;
   assign anr_req   = (wr_ctl & wr_data[CTL_AN_RST]) | pd_exit | srst_done;
   assign commit    = srst_req | anr_req;

   assign nxt_spd_pend = wr_ctl ? {wr_data[CTL_SPD_MSB], wr_data[CTL_SPD_LSB]} : spd_pend_ff;
   assign nxt_an_pend  = wr_ctl ? wr_data[CTL_AN_EN] : an_pend_ff;
   assign nxt_dup_pend = wr_ctl ? wr_data[CTL_DUP] : dup_pend_ff;

   assign forced_1g = ~an_cur_ff & (spd_cur_ff == SPD_1000);

   // ----------------------------------------------------------------
   // soft reset sequence
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff    <= ST_RUN;
         srst_cnt_ff <= 8'h00;
      end else begin
         case (state_ff)
            ST_RUN: begin
               if (srst_req) begin
                  state_ff    <= ST_SRST;
                  srst_cnt_ff <= SRST_CYC;
               end
            end
            ST_SRST: begin
               // a new request restarts the count rather than being lost
               if (srst_req) begin
                  srst_cnt_ff <= SRST_CYC;
               end else if (srst_done) begin
                  state_ff    <= ST_RUN;
                  srst_cnt_ff <= 8'h00;
               end else begin
                  srst_cnt_ff <= srst_cnt_ff - 8'h01;
               end
            end
            default: begin
               state_ff <= ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // auto-negotiation restart
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         an_cnt_ff   <= AN_RST_CYC;
         anr_busy_ff <= 1'b0;
      end else begin
         if (anr_req) begin
            an_cnt_ff <= AN_RST_CYC;
         end else if (an_cnt_ff != 8'h00) begin
            an_cnt_ff <= an_cnt_ff - 8'h01;
         end
         if (wr_ctl & wr_data[CTL_AN_RST]) begin
            anr_busy_ff <= 1'b1;
         end else if (an_cnt_ff == 8'h01) begin
            anr_busy_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register fields
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         page_ff        <= PAGE_RST;
         loop_ff        <= 1'b0;
         iso_ff         <= 1'b0;
         pd_ff          <= 1'b0;
         pd_act_prev_ff <= 1'b0;
         spd_pend_ff    <= RST_SPD;
         an_pend_ff     <= RST_AN_EN;
         dup_pend_ff    <= RST_DUP;
         spd_cur_ff     <= RST_SPD;
         an_cur_ff      <= RST_AN_EN;
         dup_cur_ff     <= RST_DUP;
      end else begin
         pd_act_prev_ff <= pd_act;
         if (wr_page) begin
            page_ff <= wr_data[7:0];
         end
         // soft reset clears loopback and isolate; power down and the deferred fields survive it
         if (srst_req) begin
            loop_ff <= 1'b0;
            iso_ff  <= 1'b0;
         end else if (wr_ctl) begin
            loop_ff <= wr_data[CTL_LOOP];
            iso_ff  <= wr_data[CTL_ISO];
         end
         if (wr_ctl) begin
            pd_ff <= wr_data[CTL_PDN];
         end
         spd_pend_ff <= nxt_spd_pend;
         an_pend_ff  <= nxt_an_pend;
         dup_pend_ff <= nxt_dup_pend;
         if (commit) begin
            spd_cur_ff <= nxt_spd_pend;
            an_cur_ff  <= nxt_an_pend;
            dup_cur_ff <= nxt_dup_pend;
         end
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         link_speed_ff <= RST_SPD;
         an_active_ff  <= RST_AN_EN;
         adv_ff        <= 6'h00;
         link_en_ff    <= 1'b0;
         mac_en_ff     <= 1'b0;
         power_down_ff <= 1'b0;
         rgmii_down_ff <= 1'b0;
         srst_pages_ff <= 8'h00;
         an_restart_ff <= 1'b1;
      end else begin
         link_speed_ff <= loop_ff ? lb_speed : spd_cur_ff;
         an_active_ff  <= an_cur_ff | forced_1g;
         adv_ff        <= forced_1g ? {dup_cur_ff, ~dup_cur_ff, 4'h0}
                                    : {adv_1000, adv_base};
         link_en_ff    <= ~loop_ff & ~pd_act & ~in_srst;
         mac_en_ff     <= ~iso_ff & ~in_srst;
         power_down_ff <= pd_act;
         rgmii_down_ff <= pd_act & ~rgmii_keepalive;
         srst_pages_ff <= in_srst ? SRST_PAGES : 8'h00;
         an_restart_ff <= anr_req | (an_cnt_ff > 8'h01);
      end
   end

   assign link_speed  = link_speed_ff;
   assign an_active   = an_active_ff;
   assign adv_ability = adv_ff;
   assign loopback    = loop_ff;
   assign link_enable = link_en_ff;
   assign mac_port_en = mac_en_ff;
   assign power_down  = power_down_ff;
   assign rgmii_down  = rgmii_down_ff;
   assign srst_pages  = srst_pages_ff;
   assign an_restart  = an_restart_ff;

endmodule

// File: rtl/cpctl_pkg.sv
/*
 * Constants, field positions, reset values and state types for the copper port
 * control register and its management-frame slave.
 * Assumes one 125 MHz system clock and a management clock sampled as plain data.
 */
package cpctl_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int         CLK_MHZ     = 125;
   localparam int         SRST_NS     = 1000;
   localparam int         AN_RST_NS   = 40;
   localparam logic [7:0] SRST_CYC    = 8'((SRST_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] AN_RST_CYC  = 8'((AN_RST_NS * CLK_MHZ + 999) / 1000);

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_CTRL    = 5'h00;
   localparam logic [4:0] REG_PAGE    = 5'h16;
   localparam logic [7:0] PAGE_COPPER = 8'h00;
   localparam logic [7:0] PAGE_RST    = 8'h00;
   localparam logic [7:0] SRST_PAGES  = 8'hAD;

   localparam int CTL_RST     = 15;
   localparam int CTL_LOOP    = 14;
   localparam int CTL_SPD_LSB = 13;
   localparam int CTL_AN_EN   = 12;
   localparam int CTL_PDN     = 11;
   localparam int CTL_ISO     = 10;
   localparam int CTL_AN_RST  = 9;
   localparam int CTL_DUP     = 8;
   localparam int CTL_SPD_MSB = 6;

   typedef enum logic [1:0] {
      SPD_10   = 2'h0,
      SPD_100  = 2'h1,
      SPD_1000 = 2'h2,
      SPD_RSVD = 2'h3
   } cpctl_speed_t;

   localparam cpctl_speed_t RST_SPD   = SPD_1000;
   localparam logic         RST_AN_EN = 1'h1;
   localparam logic         RST_DUP   = 1'h1;

   // ----------------------------------------------------------------
   // management frame
   // ----------------------------------------------------------------
   localparam logic [1:0] OP_WR       = 2'h1;
   localparam logic [1:0] OP_RD       = 2'h2;
   localparam logic [4:0] BIT_HDR_END = 5'h0D;
   localparam logic [4:0] BIT_TA1     = 5'h0E;
   localparam logic [4:0] BIT_TA2     = 5'h0F;
   localparam logic [4:0] BIT_LAST    = 5'h1F;

   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_HDR  = 2'b01,
      MS_RD   = 2'b10,
      MS_WR   = 2'b11
   } cpctl_mstate_t;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_SRST = 1'b1
   } cpctl_state_t;

endpackage

// File: rtl/cpctl_mdio_slave.sv
/*
 * Management-frame slave: decodes read and write frames on the serial
 * management pins and presents register accesses to the register bank.
 * Assumes mdc and mdio_in are synchronous to clk_sys and mdc is well below
 * half the system clock rate.
 */
`timescale 1ns/100ps
module cpctl_mdio_slave
   import cpctl_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        mdc,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   input  wire logic [4:0]  phy_addr,
   output logic [4:0]       acc_reg,
   input  wire logic [15:0] rd_data,
   output logic             wr_stb,
   output logic [15:0]      wr_data
);

   cpctl_mstate_t state_ff;
   logic          mdc_prev_ff;
   logic          bit_last_ff;
   logic [4:0]    cnt_ff;
   logic [12:0]   hdr_ff;
   logic [15:0]   sh_ff;
   wire           rise;
   wire           hdr_ok;
   wire  [1:0]    op;

   assign rise    = mdc & ~mdc_prev_ff;
   assign op      = hdr_ff[11:10];
   assign hdr_ok  = hdr_ff[12] & (hdr_ff[9:5] == phy_addr);
   assign acc_reg = hdr_ff[4:0];

   // ----------------------------------------------------------------
   // frame engine, one step per management clock rise
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff    <= MS_IDLE;
         mdc_prev_ff <= 1'b0;
         bit_last_ff <= 1'b1;
         cnt_ff      <= 5'h00;
         hdr_ff      <= 13'h0000;
         sh_ff       <= 16'h0000;
         mdio_out    <= 1'b0;
         mdio_oe     <= 1'b0;
         wr_stb      <= 1'b0;
         wr_data     <= 16'h0000;
      end else begin
         mdc_prev_ff <= mdc;
         wr_stb      <= 1'b0;
         if (rise) begin
            bit_last_ff <= mdio_in;
            cnt_ff      <= cnt_ff + 5'h01;
            case (state_ff)
               MS_IDLE: begin
                  // preamble may be suppressed: a 1 then 0 opens a frame
                  cnt_ff <= 5'h01;
                  if (bit_last_ff & ~mdio_in) begin
                     state_ff <= MS_HDR;
                  end
               end
               MS_HDR: begin
                  if (cnt_ff <= BIT_HDR_END) begin
                     hdr_ff <= {hdr_ff[11:0], mdio_in};
                  end else if (hdr_ok && op == OP_RD) begin
                     state_ff <= MS_RD;
                     sh_ff    <= rd_data;
                     mdio_oe  <= 1'b1;
                     mdio_out <= 1'b0;
                  end else if (hdr_ok && op == OP_WR) begin
                     state_ff <= MS_WR;
                  end else begin
                     state_ff <= MS_IDLE;
                  end
               end
               MS_RD: begin
                  if (cnt_ff == BIT_LAST) begin
                     mdio_oe  <= 1'b0;
                     mdio_out <= 1'b0;
                     state_ff <= MS_IDLE;
                  end else begin
                     mdio_out <= sh_ff[15];
                     sh_ff    <= {sh_ff[14:0], 1'b0};
                  end
               end
               MS_WR: begin
                  if (cnt_ff > BIT_TA2) begin
                     sh_ff <= {sh_ff[14:0], mdio_in};
                  end
                  if (cnt_ff == BIT_LAST) begin
                     wr_stb   <= 1'b1;
                     wr_data  <= {sh_ff[14:0], mdio_in};
                     state_ff <= MS_IDLE;
                  end
               end
               default: begin
                  state_ff <= MS_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// File: sim/cpctl_props.sv
/* Port checker for the copper control register block.
   Assumes one clock domain and an active high asynchronous reset. */
`timescale 1ns/100ps
module cpctl_props
   import cpctl_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       mdc,
   input wire logic       mdio_out,
   input wire logic       mdio_oe,
   input wire logic       pd_ext,
   input wire logic       rgmii_keepalive,
   input wire logic [1:0] lb_speed,
   input wire logic [3:0] adv_base,
   input wire logic [1:0] link_speed,
   input wire logic       an_active,
   input wire logic [5:0] adv_ability,
   input wire logic       loopback,
   input wire logic       link_enable,
   input wire logic       mac_port_en,
   input wire logic       power_down,
   input wire logic       rgmii_down,
   input wire logic [7:0] srst_pages,
   input wire logic       an_restart
);
   // ------------------------------------------------------------
   // soft reset length counter
   // ------------------------------------------------------------
   logic [7:0] srst_len_ff;
   logic [7:0] nxt_srst_len;

   assign nxt_srst_len = (srst_pages != 8'h00) ? srst_len_ff + 8'h01 : 8'h00;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         srst_len_ff <= 8'h00;
      end else begin
         srst_len_ff <= nxt_srst_len;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_srst_gate: assert property (srst_pages != 8'h00 |-> srst_pages == SRST_PAGES
      && !link_enable && !mac_port_en) else $error("soft reset gating wrong");
   a_srst_length: assert property (srst_pages == 8'h00 && srst_len_ff != 8'h00
      |-> srst_len_ff >= SRST_CYC) else $error("soft reset too short");
   a_link_gate: assert property (link_enable |-> !$past(loopback) && !power_down)
      else $error("link allowed in loopback or power down");
   a_loop_speed: assert property ($past(loopback) && !$past(rst)
      |-> link_speed == $past(lb_speed)) else $error("loopback speed not taken");
   a_forced_adv: assert property (!$past(rst) && adv_ability[3:0] != $past(adv_base)
      |-> adv_ability[3:0] == 4'h0 && adv_ability[5] != adv_ability[4] && an_active)
      else $error("forced advertisement wrong");
   a_pd_joint: assert property (!$past(rst) && $past(pd_ext) |-> power_down)
      else $error("second power-down bit ignored");
   a_rgmii_keep: assert property (rgmii_down == (power_down && !$past(rgmii_keepalive)))
      else $error("rgmii shutdown wrong");
   a_srst_restart: assert property ($fell(srst_pages != 8'h00) |-> ##[0:2] an_restart)
      else $error("no restart after soft reset");
   a_restart_len: assert property ($rose(an_restart) |-> an_restart[*4] ##[1:4] !an_restart)
      else $error("restart length wrong");
   a_oe_on_rise: assert property ($changed(mdio_oe) |-> $past(mdc) && !$past(mdc, 2))
      else $error("mdio drive changed off an mdc rise");
   a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround not driven low");
endmodule

bind cpctl_copper_ctrl cpctl_props u_props (
   .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
   .pd_ext(pd_ext), .rgmii_keepalive(rgmii_keepalive), .lb_speed(lb_speed),
   .adv_base(adv_base), .link_speed(link_speed), .an_active(an_active),
   .adv_ability(adv_ability), .loopback(loopback), .link_enable(link_enable),
   .mac_port_en(mac_port_en), .power_down(power_down), .rgmii_down(rgmii_down),
   .srst_pages(srst_pages), .an_restart(an_restart)
);

// File: sim/cpctl_mdio_master.sv
/* Station management master model: makes mdc only within frames and drives
   or releases the data wire.
   Assumes mdio_oe marks the device's drive and the wire has a pull-up. */
`timescale 1ns/100ps
module cpctl_mdio_master
   import cpctl_pkg::*;
(
   input  wire logic clk_sys,
   output logic      mdc,
   output logic      mdio_wire,
   input  wire logic mdio_out,
   input  wire logic mdio_oe
);
   logic drv_en;
   logic drv_d;

   // released wire floats to the pull-up level
   assign mdio_wire = mdio_oe ? mdio_out : (drv_en ? drv_d : 1'b1);

   initial begin
      mdc = 1'b0;
      drv_en = 1'b0;
      drv_d = 1'b1;
   end

   // ------------------------------------------------------------
   // one frame: two idle ones, header, turnaround, data
   // ------------------------------------------------------------
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [33:0] fr;
      fr = {4'hD, op, pa, ra, 2'h2, wd};
      rd = 16'h0000;
      for (int k = 0; k < 34; k++) begin
         @(negedge clk_sys);
         mdc = 1'b0;
         // device bit has stood since half a clock after the mdc rise
         if (op == OP_RD && k >= 18) begin
            rd[33-k] = mdio_wire;
         end
         drv_en = !(op == OP_RD && k >= 16);
         drv_d = fr[33-k];
         @(negedge clk_sys);
         @(negedge clk_sys);
         mdc = 1'b1;
         @(negedge clk_sys);
      end
      @(negedge clk_sys);
      mdc = 1'b0;
      drv_en = 1'b0;
   endtask
endmodule

// File: sim/copper_port_control_register_bench.sv
/* Self-checking bench for the copper control register.
   Assumes the master model owns mdc and resolves the mdio wire. */
`timescale 1ns/100ps
module copper_port_control_register_bench
   import cpctl_pkg::*;
;
   localparam logic [4:0] PA = 5'h03;

   typedef struct packed {
      logic [15:0] wr;
      logic [1:0]  spd;
      logic        an;
      logic [5:0]  adv;
      logic        lp;
      logic        le;
      logic        mac;
      logic [15:0] rd;
   } cpctl_row_t;

   // ordinary writes, all with the restart bit so deferred fields commit
   cpctl_row_t rows [7] = '{
      '{16'h1340, 2'h2, 1'h1, 6'h1A, 1'h0, 1'h1, 1'h1, 16'h1140},
      '{16'h0340, 2'h2, 1'h1, 6'h20, 1'h0, 1'h1, 1'h1, 16'h0140},
      '{16'h0240, 2'h2, 1'h1, 6'h10, 1'h0, 1'h1, 1'h1, 16'h0040},
      '{16'h2300, 2'h1, 1'h0, 6'h1A, 1'h0, 1'h1, 1'h1, 16'h2100},
      '{16'h0200, 2'h0, 1'h0, 6'h1A, 1'h0, 1'h1, 1'h1, 16'h0000},
      '{16'h4200, 2'h1, 1'h0, 6'h1A, 1'h1, 1'h0, 1'h1, 16'h4000},
      '{16'h0600, 2'h0, 1'h0, 6'h1A, 1'h0, 1'h1, 1'h0, 16'h0400}};

   logic        clk_sys, rst, mdc, mdio_wire, mdio_out, mdio_oe;
   logic        pd_ext, rgmii_keepalive, an_active, loopback, link_enable;
   logic        mac_port_en, power_down, rgmii_down, an_restart;
   logic [1:0]  lb_speed, adv_1000, link_speed;
   logic [3:0]  adv_base;
   logic [5:0]  adv_ability;
   logic [7:0]  srst_pages;
   logic [15:0] v;
   int          fails = 0;
   int          n_tests = 0;

   cpctl_mdio_master u_mgmt (.clk_sys(clk_sys), .mdc(mdc), .mdio_wire(mdio_wire),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe));

   cpctl_copper_ctrl dut (.clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_in(mdio_wire),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(PA), .pd_ext(pd_ext),
      .rgmii_keepalive(rgmii_keepalive), .lb_speed(lb_speed), .adv_base(adv_base),
      .adv_1000(adv_1000), .link_speed(link_speed), .an_active(an_active),
      .adv_ability(adv_ability), .loopback(loopback), .link_enable(link_enable),
      .mac_port_en(mac_port_en), .power_down(power_down), .rgmii_down(rgmii_down),
      .srst_pages(srst_pages), .an_restart(an_restart));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic cmp_reg(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cmp_out(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] pa, input logic [15:0] d);
      logic [15:0] junk;
      u_mgmt.frame(OP_WR, pa, REG_CTRL, d, junk);
   endtask

   task automatic rd(input logic [4:0] pa, output logic [15:0] d);
      u_mgmt.frame(OP_RD, pa, REG_CTRL, 16'h0000, d);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // a whole run is about 30 frames of 140 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      $display("mismatch watchdog expected finish seen hang");
      test_done();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      pd_ext = 1'b0;
      rgmii_keepalive = 1'b0;
      lb_speed = 2'h1;
      adv_base = 4'hA;
      adv_1000 = 2'h1;
      idle(4);
      rst = 1'b0;
      idle(1);
      cmp_out("reset_restart", 8'h01, 8'(an_restart));
      rd(PA, v);
      cmp_reg("reset_value", 16'h1140, v);
      wr(PA, 16'h2100);
      idle(10);
      cmp_out("held_speed", 8'h02, 8'(link_speed));
      rd(PA, v);
      cmp_reg("pending_read", 16'h2100, v);
      foreach (rows[i]) begin
         wr(PA, rows[i].wr);
         idle(1);
         cmp_out("restart_run", 8'h01, 8'(an_restart));
         idle(10);
         cmp_out("link_speed", 8'(rows[i].spd), 8'(link_speed));
         cmp_out("an_active", 8'(rows[i].an), 8'(an_active));
         cmp_out("adv_ability", 8'(rows[i].adv), 8'(adv_ability));
         cmp_out("loopback", 8'(rows[i].lp), 8'(loopback));
         cmp_out("link_enable", 8'(rows[i].le), 8'(link_enable));
         cmp_out("mac_port_en", 8'(rows[i].mac), 8'(mac_port_en));
         rd(PA, v);
         cmp_reg("readback", rows[i].rd, v);
      end
      wr(PA, 16'h5540);
      idle(3);
      cmp_out("loop_on", 8'h01, 8'(loopback));
      wr(PA, 16'hD540);
      idle(1);
      cmp_out("srst_pages", SRST_PAGES, srst_pages);
      cmp_out("srst_mac", 8'h00, 8'(mac_port_en));
      rd(PA, v);
      cmp_reg("srst_busy", 16'h8000, v & 16'h8000);
      idle(130);
      rd(PA, v);
      cmp_reg("srst_done", 16'h1140, v);
      wr(PA, 16'h1940);
      idle(3);
      cmp_out("power_down", 8'h01, 8'(power_down));
      cmp_out("rgmii_down", 8'h01, 8'(rgmii_down));
      rgmii_keepalive = 1'b1;
      idle(3);
      cmp_out("rgmii_kept", 8'h00, 8'(rgmii_down));
      wr(PA, 16'h9940);
      idle(140);
      rd(PA, v);
      cmp_reg("pdn_retained", 16'h1940, v);
      pd_ext = 1'b1;
      wr(PA, 16'h1140);
      idle(3);
      cmp_out("pd_joint", 8'h01, 8'(power_down));
      pd_ext = 1'b0;
      idle(3);
      cmp_out("wake_srst", SRST_PAGES, srst_pages);
      cmp_out("wake_restart", 8'h01, 8'(an_restart));
      idle(140);
      cmp_out("awake_link", 8'h01, 8'(link_enable));
      wr(5'h04, 16'h4000);
      idle(3);
      cmp_out("foreign_write", 8'h00, 8'(loopback));
      rd(5'h04, v);
      cmp_reg("foreign_read", 16'hFFFF, v);
      u_mgmt.frame(OP_WR, PA, REG_PAGE, 16'h0002, v);
      u_mgmt.frame(OP_RD, PA, REG_PAGE, 16'h0000, v);
      cmp_reg("page_read", 16'h0002, v);
      wr(PA, 16'h4000);
      rd(PA, v);
      cmp_reg("page_gate", 16'h0000, v);
      u_mgmt.frame(OP_WR, PA, REG_PAGE, 16'h0000, v);
      idle(3);
      cmp_out("page_gated_write", 8'h00, 8'(loopback));
      rd(PA, v);
      cmp_reg("page_back", 16'h1140, v);
      test_done();
   end
endmodule
